// ===== hdl/rx_status.sv
// Receive status logic: channel check, link quality, frame buffer path
`timescale 1ns/1ps

module frame_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// Summary of operation
// - Energy above threshold reports channel busy
// - Threshold bits 3:0, reset 7, 2 dB steps
// - Modes 0 and 3 combine energy with carrier
// - Mode 0 OR, 1 energy, 2 carrier, 3 AND
// - Link quality is an integer 0 to 255
// - Link quality from several symbol correlations
// - Link quality valid only for two octets upward
// - Link quality ready with the frame end event
// - Link quality appended to stored frame for host
// - Basic mode raises start event on frame begin
// - Basic mode raises frame end event on completion
// - Update frame energy and checksum status afterwards
// - Latch frequency offset, correct rest of frame
// - Correction spans up to 120 ppm deviation
// - Demodulated bytes written into frame buffer
// - Extended mode filters address, reports pending data
module rx_status #(
  parameter logic [7:0] SIGNAL_FLOOR = rx_status_pkg::SIGNAL_FLOOR_RESET,
  parameter int DEPTH = rx_status_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] energy_level,
  input wire logic carrier_sense,
  input wire logic rx_start_det,
  input wire logic rx_byte_valid,
  input wire rx_status_pkg::fb_word_t rx_byte,
  output logic rx_byte_ready,
  input wire logic fcs_ok,
  input wire logic sym_valid,
  input wire logic [7:0] sym_corr,
  input wire logic freq_est_valid,
  input wire logic signed [7:0] freq_est,
  output logic signed [7:0] freq_corr,
  input wire logic ext_mode,
  input wire logic addr_match,
  input wire logic pending_in,
  output logic frame_pending,
  output logic fb_valid,
  input wire logic fb_ready,
  output rx_status_pkg::fb_word_t fb_word,
  output logic rx_start_event,
  output logic frame_end_event
);
  typedef enum logic [1:0] {S_IDLE, S_RECV, S_APPEND} rx_state_t;
  localparam int TOL = rx_status_pkg::FREQ_TOL_PPM;

  rx_state_t state;
  logic [3:0] energy_busy_threshold;
  logic [1:0] channel_check_mode;
  logic [4:0] channel;
  logic check_busy;
  logic check_done;
  logic check_idle;
  logic [12:0] check_count;
  logic [7:0] check_peak;
  logic [8:0] busy_level;
  logic decision;
  logic check_fire;
  logic [10:0] lqi_sum;
  logic [3:0] lqi_syms;
  logic [7:0] octets;
  logic [7:0] lqi_byte;
  logic [7:0] frame_peak;
  logic [7:0] frame_energy_reg;
  logic fcs_seen;
  logic fcs_valid;
  logic lqi_ok;
  logic freq_locked;
  logic fifo_in_valid;
  logic fifo_in_ready;
  rx_status_pkg::fb_word_t fifo_in;
  logic fifo_out_valid;
  rx_status_pkg::fb_word_t fifo_out;
  logic fifo_pop;
  logic byte_take;
  logic append_push;
  logic end_allowed;

  // Reserved upper nibble is not part of the level: only the low field scales
  assign busy_level = 9'(SIGNAL_FLOOR) + 9'({energy_busy_threshold, 1'b0});
  assign check_fire = check_busy && (check_count == 13'(rx_status_pkg::CHECK_CYCLES - 1));

  function automatic logic check_result(input logic [1:0] mode, input logic energy_busy,
                                        input logic carrier);
    case (rx_status_pkg::check_mode_t'(mode))
      rx_status_pkg::CHECK_OR: check_result = energy_busy || carrier;
      rx_status_pkg::CHECK_ENERGY: check_result = energy_busy;
      rx_status_pkg::CHECK_CARRIER: check_result = carrier;
      rx_status_pkg::CHECK_AND: check_result = energy_busy && carrier;
      default: check_result = 1'b1;
    endcase
  endfunction

  assign decision = check_result(channel_check_mode,
                                 9'(check_peak) > busy_level, carrier_sense);

  // Register writes
  always_ff @(posedge clock) begin
    if (srst) begin
      energy_busy_threshold <= rx_status_pkg::THRESH_RESET;
      channel_check_mode <= rx_status_pkg::MODE_RESET;
      channel <= rx_status_pkg::CHANNEL_RESET;
    end else if (reg_wr && reg_addr == rx_status_pkg::ADDR_THRESH) begin
      energy_busy_threshold <= reg_wdata[3:0];
    end else if (reg_wr && reg_addr == rx_status_pkg::ADDR_CHECK) begin
      channel_check_mode <= reg_wdata[rx_status_pkg::CHECK_MODE_LSB +: 2];
      channel <= reg_wdata[4:0];
    end
  end

  // Channel check runs over a fixed window, keeping the peak energy seen
  always_ff @(posedge clock) begin
    if (srst) begin
      check_busy <= 1'b0;
      check_done <= 1'b0;
      check_idle <= 1'b0;
      check_count <= '0;
      check_peak <= '0;
    end else if (reg_wr && reg_addr == rx_status_pkg::ADDR_CHECK
                 && reg_wdata[rx_status_pkg::CHECK_REQ_BIT]) begin
      check_busy <= 1'b1;
      check_done <= 1'b0;
      check_idle <= 1'b0;
      check_count <= '0;
      check_peak <= energy_level;
    end else if (check_busy) begin
      check_count <= check_count + 1'b1;
      if (energy_level > check_peak) begin
        check_peak <= energy_level;
      end
      if (check_fire) begin
        check_busy <= 1'b0;
        check_done <= 1'b1;
        check_idle <= !decision;
      end
    end
  end

  // Register reads, one cycle after the address is presented
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        rx_status_pkg::ADDR_STATUS: reg_rdata <= {check_done, check_idle, 6'h00};
        rx_status_pkg::ADDR_SIGNAL: reg_rdata <= {fcs_valid, 6'h00, lqi_ok};
        rx_status_pkg::ADDR_ENERGY: reg_rdata <= frame_energy_reg;
        rx_status_pkg::ADDR_CHECK: reg_rdata <= {1'b0, channel_check_mode, channel};
        rx_status_pkg::ADDR_THRESH:
          reg_rdata <= {rx_status_pkg::THRESH_RSVD, energy_busy_threshold};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Frame sequencing
  assign byte_take = rx_byte_valid && rx_byte_ready;
  assign append_push = (state == S_APPEND) && fifo_in_ready;
  assign end_allowed = !ext_mode || addr_match;

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: if (rx_start_det) state <= S_RECV;
        S_RECV: if (byte_take && rx_byte.last) state <= S_APPEND;
        S_APPEND: if (append_push) state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // Ready is gated by the state flop so the link only stalls on a full buffer
  assign rx_byte_ready = (state == S_RECV) && fifo_in_ready;

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_start_event <= 1'b0;
      frame_end_event <= 1'b0;
    end else begin
      rx_start_event <= (state == S_IDLE) && rx_start_det && !ext_mode;
      frame_end_event <= append_push && end_allowed;
    end
  end

  // Link quality: mean of the first symbol correlations in the frame
  always_ff @(posedge clock) begin
    if (srst || (state == S_IDLE)) begin
      lqi_sum <= '0;
      lqi_syms <= '0;
      octets <= '0;
      frame_peak <= '0;
      fcs_seen <= 1'b0;
    end else if (state == S_RECV) begin
      if (sym_valid && lqi_syms != 4'(rx_status_pkg::LQI_SYMBOLS)) begin
        lqi_sum <= lqi_sum + 11'(sym_corr);
        lqi_syms <= lqi_syms + 1'b1;
      end
      if (byte_take && octets != 8'hFF) begin
        octets <= octets + 1'b1;
      end
      if (energy_level > frame_peak) begin
        frame_peak <= energy_level;
      end
      if (byte_take && rx_byte.last) begin
        fcs_seen <= fcs_ok;
      end
    end
  end

  // Frames shorter than two octets carry a zero quality byte
  always_comb begin
    if (octets < 8'(rx_status_pkg::MIN_LQI_OCTETS)) begin
      lqi_byte = 8'h00;
    end else begin
      lqi_byte = 8'(lqi_sum >> rx_status_pkg::LQI_SHIFT);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      frame_energy_reg <= '0;
      fcs_valid <= 1'b0;
      lqi_ok <= 1'b0;
      frame_pending <= 1'b0;
    end else if (append_push && end_allowed) begin
      frame_energy_reg <= frame_peak;
      fcs_valid <= fcs_seen;
      lqi_ok <= (octets >= 8'(rx_status_pkg::MIN_LQI_OCTETS));
      frame_pending <= ext_mode && pending_in;
    end
  end

  // Offset taken once per frame, clamped to the tolerated span
  always_ff @(posedge clock) begin
    if (srst || (state == S_IDLE)) begin
      freq_corr <= '0;
      freq_locked <= 1'b0;
    end else if (state == S_RECV && freq_est_valid && !freq_locked) begin
      freq_locked <= 1'b1;
      if (freq_est > 8'sd120) begin
        freq_corr <= -8'sd120;
      end else if (freq_est < -8'sd120) begin
        freq_corr <= 8'sd120;
      end else begin
        freq_corr <= -freq_est;
      end
    end
  end

  // Payload then quality byte into the buffer
  always_comb begin
    if (state == S_APPEND) begin
      fifo_in_valid = 1'b1;
      fifo_in = '{last: 1'b1, data: lqi_byte};
    end else begin
      fifo_in_valid = rx_byte_valid && (state == S_RECV);
      fifo_in = '{last: 1'b0, data: rx_byte.data};
    end
  end

  frame_fifo #(.WIDTH($bits(rx_status_pkg::fb_word_t)), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .srst(srst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  assign fifo_pop = fifo_out_valid && (!fb_valid || fb_ready);

  always_ff @(posedge clock) begin
    if (srst) begin
      fb_valid <= 1'b0;
      fb_word <= '0;
    end else if (!fb_valid || fb_ready) begin
      fb_valid <= fifo_out_valid;
      fb_word <= fifo_out;
    end
  end

  chk_energy_busy: assert property (@(posedge clock) disable iff (srst)
    check_fire && channel_check_mode == 2'h1 |=> check_idle == !$past(9'(check_peak) > busy_level))
    else $error("energy check result wrong");
  chk_thresh_reset: assert property (@(posedge clock)
    srst |=> energy_busy_threshold == 4'h7)
    else $error("threshold reset value wrong");
  chk_and_mode: assert property (@(posedge clock) disable iff (srst)
    check_fire && channel_check_mode == 2'h3 && !carrier_sense |=> check_idle && check_done)
    else $error("and mode reported busy without carrier");
  chk_carrier_mode: assert property (@(posedge clock) disable iff (srst)
    check_fire && channel_check_mode == 2'h2 |=> check_idle == !$past(carrier_sense))
    else $error("carrier mode result wrong");
  chk_short_lqi: assert property (@(posedge clock) disable iff (srst)
    append_push && octets < 8'h02 |-> fifo_in.data == 8'h00 && fifo_in.last)
    else $error("short frame carried quality");
  chk_end_event: assert property (@(posedge clock) disable iff (srst)
    append_push && !ext_mode |=> frame_end_event && state == S_IDLE)
    else $error("frame end not with quality byte");
  chk_start_event: assert property (@(posedge clock) disable iff (srst)
    state == S_IDLE && rx_start_det && !ext_mode |=> rx_start_event && state == S_RECV)
    else $error("start event missing");
  chk_freq_hold: assert property (@(posedge clock) disable iff (srst)
    state == S_RECV && freq_locked |=> $stable(freq_corr))
    else $error("offset correction changed in frame");
  chk_freq_span: assert property (@(posedge clock) disable iff (srst)
    freq_corr <= $signed(8'(TOL)) && freq_corr >= -$signed(8'(TOL)))
    else $error("offset correction out of span");
  chk_fcs_update: assert property (@(posedge clock) disable iff (srst)
    append_push && !ext_mode |=> fcs_valid == $past(fcs_seen))
    else $error("checksum status not updated");
  chk_rsvd_read: assert property (@(posedge clock) disable iff (srst)
    reg_addr == 6'h09 |=> reg_rdata[7:4] == 4'hC)
    else $error("reserved bits read wrong");

  cov_check_done: cover property (@(posedge clock) disable iff (srst) check_fire);
  cov_frame_end: cover property (@(posedge clock) disable iff (srst) frame_end_event);
  cov_fifo_full: cover property (@(posedge clock) disable iff (srst)
    state == S_RECV && !fifo_in_ready);
  cov_filtered: cover property (@(posedge clock) disable iff (srst)
    append_push && !end_allowed);
endmodule

// ===== pkg/rx_status_pkg.sv
// Constants, register map and types for the receive status block
package rx_status_pkg;
  localparam logic [5:0] ADDR_STATUS = 6'h01;
  localparam logic [5:0] ADDR_SIGNAL = 6'h06;
  localparam logic [5:0] ADDR_ENERGY = 6'h07;
  localparam logic [5:0] ADDR_CHECK = 6'h08;
  localparam logic [5:0] ADDR_THRESH = 6'h09;

  localparam int CHECK_REQ_BIT = 7;
  localparam int CHECK_MODE_LSB = 5;
  localparam int DONE_BIT = 7;
  localparam int IDLE_BIT = 6;
  localparam int FCS_BIT = 7;
  localparam int LQI_OK_BIT = 0;

  localparam logic [3:0] THRESH_RESET = 4'h7;
  localparam logic [3:0] THRESH_RSVD = 4'hC;
  localparam logic [1:0] MODE_RESET = 2'h1;
  localparam logic [4:0] CHANNEL_RESET = 5'h0B;
  localparam logic [7:0] SIGNAL_FLOOR_RESET = 8'h00;

  localparam int THRESH_STEP_DB = 2;
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int CHECK_TIME_NS = 128000;
  localparam int CHECK_CYCLES = CHECK_TIME_NS / CLOCK_PERIOD_NS;
  localparam int LQI_SYMBOLS = 8;
  localparam int LQI_SHIFT = 3;
  localparam int MIN_LQI_OCTETS = 2;
  localparam int FREQ_TOL_PPM = 120;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    CHECK_OR,
    CHECK_ENERGY,
    CHECK_CARRIER,
    CHECK_AND
  } check_mode_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } fb_word_t;
endpackage

// ===== bench/host_model.sv
// Host side model: drains the frame buffer port at a chosen pace
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic [1:0] pace,
  input wire logic fb_valid,
  input wire rx_status_pkg::fb_word_t fb_word,
  output logic fb_ready
);
  rx_status_pkg::fb_word_t got[$];
  logic [1:0] tick;
  // Slow pace takes one word in three so the buffer backs up
  always_ff @(posedge clock) begin
    if (srst) begin
      tick <= 2'h0;
      fb_ready <= 1'b0;
    end else begin
      tick <= (tick == 2'h2) ? 2'h0 : tick + 2'h1;
      fb_ready <= (pace == 2'h0) || (tick == 2'h0);
    end
  end
  always @(posedge clock) begin
    if (!srst && fb_valid && fb_ready) begin
      got.push_back(fb_word);
    end
  end
endmodule

// ===== bench/rx_cca_threshold_lqi_tb.sv
// Self-checking bench for the receive status block
`timescale 1ns/1ps
module rx_cca_threshold_lqi_tb;
  localparam logic [7:0] FLOOR = 8'h10;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] energy_level = 8'h00;
  logic carrier_sense = 1'b0;
  logic rx_start_det = 1'b0;
  logic rx_byte_valid = 1'b0;
  rx_status_pkg::fb_word_t rx_byte = '0;
  logic rx_byte_ready;
  logic fcs_ok = 1'b0;
  logic sym_valid = 1'b0;
  logic [7:0] sym_corr = 8'h00;
  logic freq_est_valid = 1'b0;
  logic signed [7:0] freq_est = 8'sh00;
  logic signed [7:0] freq_corr;
  logic ext_mode = 1'b0;
  logic addr_match = 1'b0;
  logic pending_in = 1'b0;
  logic frame_pending;
  logic fb_valid;
  logic fb_ready;
  rx_status_pkg::fb_word_t fb_word;
  logic rx_start_event;
  logic frame_end_event;
  logic [1:0] pace = 2'h0;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_start = 0;
  int n_end = 0;
  int stalls = 0;
  // Status registers hold the last accepted frame; filtered frames leave them alone
  logic [7:0] last_en = 8'h00;
  logic last_fcs = 1'b0;
  logic last_lqi = 1'b0;
  logic last_pend = 1'b0;

  always #20 clock = ~clock;

  rx_status #(.SIGNAL_FLOOR(FLOOR), .DEPTH(16)) DUT (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .energy_level(energy_level),
    .carrier_sense(carrier_sense), .rx_start_det(rx_start_det),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_byte_ready(rx_byte_ready),
    .fcs_ok(fcs_ok), .sym_valid(sym_valid), .sym_corr(sym_corr),
    .freq_est_valid(freq_est_valid), .freq_est(freq_est), .freq_corr(freq_corr),
    .ext_mode(ext_mode), .addr_match(addr_match), .pending_in(pending_in),
    .frame_pending(frame_pending), .fb_valid(fb_valid), .fb_ready(fb_ready),
    .fb_word(fb_word), .rx_start_event(rx_start_event), .frame_end_event(frame_end_event));

  host_model host (.clock(clock), .srst(srst), .pace(pace), .fb_valid(fb_valid),
    .fb_word(fb_word), .fb_ready(fb_ready));

  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Ceiling covers ten channel checks of 3200 cycles plus the frames
  always @(posedge clock) begin
    cycles++;
    if (!srst && rx_start_event === 1'b1) n_start++;
    if (!srst && frame_end_event === 1'b1) n_end++;
    if (cycles == 80000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    @(negedge clock);
    d = reg_rdata;
  endtask

  function automatic logic exp_idle(input logic [1:0] m, input logic [3:0] t,
      input logic [7:0] e, input logic c);
    logic be;
    be = {1'b0, e} > ({1'b0, FLOOR} + {4'h0, t, 1'b0});
    case (m)
      2'h0: return !(c | be);
      2'h1: return !be;
      2'h2: return !c;
      default: return !(c & be);
    endcase
  endfunction

  function automatic logic [7:0] exp_corr(input logic signed [7:0] e);
    int x;
    x = -int'(e);
    if (x > 120) x = 120;
    if (x < -120) x = -120;
    return x[7:0];
  endfunction

  task automatic cca(input logic [1:0] m, input logic [3:0] t, input logic up,
      input logic c);
    logic [7:0] e;
    logic [7:0] d;
    int i;
    e = FLOOR + {3'h0, t, 1'b0} + {7'h00, up};
    @(posedge clock);
    energy_level <= e;
    carrier_sense <= c;
    wr(rx_status_pkg::ADDR_THRESH, {4'h0, t});
    wr(rx_status_pkg::ADDR_CHECK, {1'b1, m, 5'h0B});
    rd(rx_status_pkg::ADDR_CHECK, d);
    chk_val({1'b0, d}, {1'b0, 1'b0, m, 5'h0B});
    d = 8'h00;
    for (i = 0; i < 2000 && d[7] !== 1'b1; i++) rd(rx_status_pkg::ADDR_STATUS, d);
    chk_val({8'h00, d[7]}, 9'h001);
    chk_val({8'h00, d[6]}, {8'h00, exp_idle(m, t, e, c)});
  endtask

  task automatic frame(input int n, input logic signed [7:0] est, input logic ext,
      input logic am, input logic pend, input logic fcs, input logic [1:0] pc);
    logic [7:0] data[$];
    logic [7:0] d;
    logic [7:0] en;
    int sum;
    int i;
    int w;
    int s0;
    int e0;
    logic ok;
    sum = 0;
    en = $urandom;
    s0 = n_start;
    e0 = n_end;
    @(posedge clock);
    pace <= pc;
    energy_level <= en;
    ext_mode <= ext;
    addr_match <= am;
    pending_in <= pend;
    @(posedge clock);
    rx_start_det <= 1'b1;
    @(posedge clock);
    rx_start_det <= 1'b0;
    for (i = 0; i < 10; i++) begin
      d = $urandom;
      if (i < 8) sum += d;
      sym_valid <= 1'b1;
      sym_corr <= d;
      freq_est_valid <= (i == 2) || (i == 5);
      freq_est <= (i == 2) ? est : ~est;
      @(posedge clock);
    end
    sym_valid <= 1'b0;
    freq_est_valid <= 1'b0;
    @(negedge clock);
    chk_val({1'b0, freq_corr}, {1'b0, exp_corr(est)});
    @(posedge clock);
    for (i = 0; i < n; i++) begin
      d = $urandom;
      data.push_back(d);
      // A start pulse inside a frame must be ignored
      rx_start_det <= (i == 0);
      rx_byte_valid <= 1'b1;
      rx_byte <= '{last: (i == n - 1), data: d};
      fcs_ok <= fcs;
      w = 0;
      @(negedge clock);
      while (!rx_byte_ready && w < 300) begin
        w++;
        stalls++;
        @(negedge clock);
      end
      @(posedge clock);
    end
    rx_byte_valid <= 1'b0;
    rx_start_det <= 1'b0;
    for (w = 0; w < 3000 && host.got.size() < n + 1; w++) @(posedge clock);
    repeat (3) @(posedge clock);
    ok = !ext || am;
    chk_val(9'(n_end - e0), {8'h00, ok});
    chk_val(9'(n_start - s0), {8'h00, !ext});
    chk_val(9'(host.got.size()), 9'(n + 1));
    for (i = 0; i < n && i < host.got.size(); i++) begin
      chk_val(host.got[i], {1'b0, data[i]});
    end
    d = (n >= 2) ? 8'(sum >> 3) : 8'h00;
    if (host.got.size() == n + 1) chk_val(host.got[n], {1'b1, d});
    if (ok) begin
      last_en = en;
      last_fcs = fcs;
      last_lqi = (n >= 2);
      last_pend = ext & pend;
    end
    chk_val({8'h00, frame_pending}, {8'h00, last_pend});
    chk_val({1'b0, freq_corr}, 9'h000);
    rd(rx_status_pkg::ADDR_SIGNAL, d);
    chk_val({7'h00, d[7], d[0]}, {7'h00, last_fcs, last_lqi});
    rd(rx_status_pkg::ADDR_ENERGY, d);
    chk_val({1'b0, d}, {1'b0, last_en});
    host.got.delete();
  endtask

  initial begin
    logic [7:0] d;
    int k;
    void'($urandom(57));
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    rd(rx_status_pkg::ADDR_THRESH, d);
    chk_val({1'b0, d}, 9'h0C7);
    rd(rx_status_pkg::ADDR_CHECK, d);
    chk_val({1'b0, d}, 9'h02B);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, d);
    chk_val({1'b0, d}, 9'h000);
    wr(rx_status_pkg::ADDR_ENERGY, 8'hAA);
    rd(rx_status_pkg::ADDR_ENERGY, d);
    chk_val({1'b0, d}, 9'h000);
    wr(rx_status_pkg::ADDR_THRESH, 8'h35);
    rd(rx_status_pkg::ADDR_THRESH, d);
    chk_val({1'b0, d}, 9'h0C5);
    for (k = 0; k < 8; k++) cca(2'(k >> 1), 4'($urandom), k[0], 1'($urandom));
    cca(2'h3, 4'($urandom), 1'b1, 1'b0);
    cca(2'h0, 4'($urandom), 1'b0, 1'b1);
    frame(1, 8'sh80, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0);
    frame(2, 8'sh7F, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0);
    frame(3, 8'sh10, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0);
    stalls = 0;
    frame(40, 8'($urandom), 1'b0, 1'b1, 1'b1, 1'b1, 2'h1);
    chk_val({8'h00, stalls > 0}, 9'h001);
    for (k = 0; k < 4; k++) frame($urandom_range(8, 2), 8'($urandom), 1'b0, 1'b1, 1'b0,
      1'($urandom), 2'($urandom_range(1, 0)));
    tally_and_finish();
  end
endmodule
